// ==== hw/lbx_map.svh ====
// Constants of the ladder bit logic executor: opcodes, flag bits, sizes
`ifndef LBX_MAP_SVH
`define LBX_MAP_SVH
`define LBX_PADDR_W      10
`define LBX_IWORD_W      16
`define LBX_BIT_ADDR_W   12
`define LBX_STACK_DEPTH  8
`define LBX_STACK_PTR_W  4
`define LBX_OP_SHIFT     12
`define LBX_OP_END       8'h01
`define LBX_FLAG_BASE    12'h0C0
`define LBX_FLAG_FAULT   4'hB
`define LBX_FLAG_CARRY   4'hC
`define LBX_FLAG_BELOW   4'hD
`define LBX_FLAG_MATCH   4'hE
`define LBX_FLAG_ABOVE   4'hF
`define LBX_FLAG_WORD    12'h003
`define LBX_DR_WORD      12'h020
`define LBX_DR_LAST      8'h15
`define LBX_PTR_MARK     12'h800
`endif

// ==== hw/lbx_pkg.sv ====
// Types of the ladder bit logic executor
package lbx_pkg;
	typedef enum logic [3:0]
	{
		LBX_OP_NOP,
		LBX_OP_LOAD,
		LBX_OP_LOAD_INV,
		LBX_OP_SERIES,
		LBX_OP_SERIES_INV,
		LBX_OP_PARALLEL,
		LBX_OP_PARALLEL_INV,
		LBX_OP_BLK_SERIES,
		LBX_OP_BLK_PARALLEL,
		LBX_OP_COIL,
		LBX_OP_COIL_INV,
		LBX_OP_FUNC
	} lbx_op_t;
	typedef struct packed
	{
		logic fault;
		logic carry;
		logic below;
		logic match;
		logic above;
	} lbx_flags_t;
	typedef struct packed
	{
		logic        en;
		logic [11:0] addr;
		logic        value;
	} lbx_bit_wr_t;
endpackage

// ==== hw/lbx_cond_stack.sv ====
// Register stack of pending execution conditions
`include "lbx_map.svh"
module lbx_cond_stack
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic clear,
	input  wire logic push,
	input  wire logic push_val,
	input  wire logic pop,
	output logic      top_val,
	output logic      empty,
	output logic      full
);
	logic [`LBX_STACK_DEPTH-1:0] mem_r;
	logic [`LBX_STACK_DEPTH-1:0] mem_nxt;
	logic [`LBX_STACK_PTR_W-1:0] cnt_r;
	logic [`LBX_STACK_PTR_W-1:0] cnt_nxt;
	logic                        top_r;

	assign empty   = (cnt_r == 4'h0);
	assign full    = (cnt_r == 4'h8);
	assign top_val = top_r;

	always_comb
	begin
		mem_nxt = mem_r;
		cnt_nxt = cnt_r;
		if (clear)
			cnt_nxt = 4'h0;
		else if (push && !full)
		begin
			mem_nxt = {mem_r[`LBX_STACK_DEPTH-2:0], push_val};
			cnt_nxt = cnt_r + 4'h1;
		end
		else if (pop && !empty)
		begin
			mem_nxt = {1'b0, mem_r[`LBX_STACK_DEPTH-1:1]};
			cnt_nxt = cnt_r - 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mem_r <= 8'h00;
			cnt_r <= 4'h0;
			top_r <= 1'b0;
		end
		else
		begin
			mem_r <= mem_nxt;
			cnt_r <= cnt_nxt;
			top_r <= mem_nxt[0];
		end
	end
endmodule

// ==== hw/lbx_executor.sv ====
// Ladder bit logic executor: decodes condition, block and coil instructions
// Function
// - Five status flags at bits 0311..0315
// - Set fault flag on execution or operand error
// - Skip instruction while fault flag set
// - Pointer operand fetches address from retained word
// - First word opcode; operands follow in order
// - Constants interpreted in instruction's number format
// - No run without terminator at last address
// - Load starts condition, inverted load inverts
// - Series contact ANDs operand bit
// - Parallel contact ORs operand bit
// - Block joins combine with last unused condition
// - Multi-input lines coded as load blocks first
// - Coil writes condition to its bit
// - Inverted coil writes inverse condition
// - Bit instructions change only the fault flag, on error
// - Function instructions use two-digit decimal code
`include "lbx_map.svh"
module lbx_executor
(
	input  wire logic                     clk,
	input  wire logic                     rstn,
	input  wire logic                     run_mode,
	output logic [`LBX_PADDR_W-1:0]      prog_addr,
	input  wire logic [`LBX_IWORD_W-1:0] prog_word,
	input  wire logic                     last_is_end,
	output logic [`LBX_BIT_ADDR_W-1:0]   bit_rd_addr,
	input  wire logic                     bit_rd_val,
	output logic [`LBX_BIT_ADDR_W-1:0]   word_rd_addr,
	input  wire logic [15:0]              word_rd_val,
	output lbx_pkg::lbx_bit_wr_t          bit_wr,
	output lbx_pkg::lbx_flags_t           flags,
	output logic                          running,
	output logic                          scan_done
);
	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_PTR, S_BIT, S_EXEC} lbx_state_t;

	lbx_state_t                  state_r, state_nxt;
	logic [`LBX_PADDR_W-1:0]     pc_r, pc_nxt;
	logic [`LBX_IWORD_W-1:0]     ir_r, ir_nxt;
	logic [`LBX_BIT_ADDR_W-1:0]  baddr_r, baddr_nxt;
	logic                        cond_r, cond_nxt;
	lbx_pkg::lbx_flags_t         flags_r, flags_nxt;
	lbx_pkg::lbx_bit_wr_t        wr_r, wr_nxt;
	logic                        done_r, done_nxt;
	logic                        st_clear, st_push, st_pop, st_top, st_empty, st_full;
	lbx_pkg::lbx_op_t            op;
	logic [15:0]                 flag_word;
	logic                        opnd;
	logic [7:0]                  ptr;
	logic                        ptr_bad;

	lbx_cond_stack u_stack
	(
		.clk      (clk),
		.rstn     (rstn),
		.clear    (st_clear),
		.push     (st_push),
		.push_val (cond_r),
		.pop      (st_pop),
		.top_val  (st_top),
		.empty    (st_empty),
		.full     (st_full)
	);

	// Word layout: [15:12] opcode, [11:0] bit operand or function code in BCD
	assign op    = lbx_pkg::lbx_op_t'(ir_r[15:12]);
	assign ptr   = word_rd_val[7:0];
	// Pointer must be two BCD digits no higher than 15, upper digits zero
	assign ptr_bad = (word_rd_val[15:8] != 8'h00) || (ptr[3:0] > 4'h9) || (ptr > `LBX_DR_LAST);

	assign prog_addr    = pc_r;
	assign bit_rd_addr  = baddr_r;
	assign word_rd_addr = `LBX_DR_WORD + {4'h0, ir_r[7:0]};
	assign bit_wr       = wr_r;
	assign flags        = flags_r;
	assign running      = (state_r != S_IDLE);
	assign scan_done    = done_r;
	// Flag bits 11..15 of the flag word read back as contacts; the memory copy there is ignored
	assign flag_word = {flags_r.above, flags_r.match, flags_r.below, flags_r.carry, flags_r.fault, 11'h000};
	assign opnd      = ({4'h0, baddr_r[11:4]} == `LBX_FLAG_WORD && baddr_r[3:0] >= `LBX_FLAG_FAULT) ?
	                   flag_word[baddr_r[3:0]] : bit_rd_val;

	always_comb
	begin
		state_nxt = state_r;
		pc_nxt    = pc_r;
		ir_nxt    = ir_r;
		baddr_nxt = baddr_r;
		cond_nxt  = cond_r;
		flags_nxt = flags_r;
		wr_nxt    = '0;
		done_nxt  = 1'b0;
		st_clear  = 1'b0;
		st_push   = 1'b0;
		st_pop    = 1'b0;
		case (state_r)
			S_IDLE:
			begin
				// A program without terminator never starts
				if (run_mode && last_is_end)
				begin
					state_nxt = S_FETCH;
					pc_nxt    = '0;
					st_clear  = 1'b1;
				end
			end
			S_FETCH:
			begin
				ir_nxt = prog_word;
				if (prog_word[15:12] == 4'hB && prog_word[7:0] == `LBX_OP_END)
				begin
					// Terminator: restart scan at zero
					done_nxt  = 1'b1;
					pc_nxt    = '0;
					st_clear  = 1'b1;
					flags_nxt.fault = 1'b0;
					if (!run_mode)
						state_nxt = S_IDLE;
				end
				else if (prog_word[11] && prog_word[15:12] != 4'hB)
					state_nxt = S_PTR;
				else
				begin
					baddr_nxt = prog_word[11:0];
					state_nxt = S_BIT;
				end
			end
			S_PTR:
			begin
				// Pointer word read: its BCD value selects the real retained word
				if (ptr_bad)
				begin
					flags_nxt.fault = 1'b1;
					pc_nxt    = pc_r + 10'h001;
					state_nxt = S_FETCH;
				end
				else
				begin
					baddr_nxt = `LBX_DR_WORD * 12'h010 + {4'h0, ptr[7:4], 4'h0} * 12'h00A
					            + {4'h0, ptr[3:0], 4'h0} + {8'h00, ir_r[11:8] & 4'h7};
					state_nxt = S_BIT;
				end
			end
			S_BIT:
				state_nxt = S_EXEC;
			S_EXEC:
			begin
				pc_nxt    = pc_r + 10'h001;
				state_nxt = S_FETCH;
				// A pending fault blocks execution of the instruction
				if (!flags_r.fault)
				begin
					// Flags are written only by fault detection
					case (op)
						lbx_pkg::LBX_OP_LOAD,
						lbx_pkg::LBX_OP_LOAD_INV:
						begin
							if (st_full)
								flags_nxt.fault = 1'b1;
							st_push  = 1'b1;
							cond_nxt = opnd ^ (op == lbx_pkg::LBX_OP_LOAD_INV);
						end
						lbx_pkg::LBX_OP_SERIES:       cond_nxt = cond_r & opnd;
						lbx_pkg::LBX_OP_SERIES_INV:   cond_nxt = cond_r & ~opnd;
						lbx_pkg::LBX_OP_PARALLEL:     cond_nxt = cond_r | opnd;
						lbx_pkg::LBX_OP_PARALLEL_INV: cond_nxt = cond_r | ~opnd;
						lbx_pkg::LBX_OP_BLK_SERIES,
						lbx_pkg::LBX_OP_BLK_PARALLEL:
						begin
							// A join with nothing pending is an operand error
							if (st_empty)
								flags_nxt.fault = 1'b1;
							else
							begin
								st_pop   = 1'b1;
								cond_nxt = (op == lbx_pkg::LBX_OP_BLK_SERIES) ?
								           (cond_r & st_top) : (cond_r | st_top);
							end
						end
						lbx_pkg::LBX_OP_COIL,
						lbx_pkg::LBX_OP_COIL_INV:
						begin
							wr_nxt.en    = 1'b1;
							wr_nxt.addr  = baddr_r;
							wr_nxt.value = cond_r ^ (op == lbx_pkg::LBX_OP_COIL_INV);
						end
						lbx_pkg::LBX_OP_NOP:
							cond_nxt = cond_r;
						default:
							flags_nxt.fault = 1'b1;
					endcase
				end
			end
			default:
				state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= S_IDLE;
			pc_r    <= '0;
			ir_r    <= 16'h0000;
			baddr_r <= 12'h000;
			cond_r  <= 1'b0;
			flags_r <= '0;
			wr_r    <= '0;
			done_r  <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			pc_r    <= pc_nxt;
			ir_r    <= ir_nxt;
			baddr_r <= baddr_nxt;
			cond_r  <= cond_nxt;
			flags_r <= flags_nxt;
			wr_r    <= wr_nxt;
			done_r  <= done_nxt;
		end
	end

	property p_no_run_without_end;
		@(posedge clk) disable iff (!rstn)
		(state_r == S_IDLE && !last_is_end) |=> (state_r == S_IDLE);
	endproperty
	a_no_run_without_end: assert property (p_no_run_without_end) else $error("started without terminator");

	property p_coil_value;
		@(posedge clk) disable iff (!rstn)
		(state_r == S_EXEC && !flags_r.fault && op == lbx_pkg::LBX_OP_COIL) |=> (bit_wr.en && bit_wr.value == $past(cond_r));
	endproperty
	a_coil_value: assert property (p_coil_value) else $error("coil value wrong");

	property p_coil_inv_value;
		@(posedge clk) disable iff (!rstn)
		(state_r == S_EXEC && !flags_r.fault && op == lbx_pkg::LBX_OP_COIL_INV) |=> (bit_wr.en && bit_wr.value != $past(cond_r));
	endproperty
	a_coil_inv_value: assert property (p_coil_inv_value) else $error("inverted coil value wrong");

	property p_load;
		@(posedge clk) disable iff (!rstn)
		(state_r == S_EXEC && !flags_r.fault && op == lbx_pkg::LBX_OP_LOAD) |=> (cond_r == $past(opnd));
	endproperty
	a_load: assert property (p_load) else $error("load condition wrong");

	property p_series;
		@(posedge clk) disable iff (!rstn)
		(state_r == S_EXEC && !flags_r.fault && op == lbx_pkg::LBX_OP_SERIES) |=> (cond_r == ($past(cond_r) & $past(opnd)));
	endproperty
	a_series: assert property (p_series) else $error("series contact wrong");

	property p_parallel;
		@(posedge clk) disable iff (!rstn)
		(state_r == S_EXEC && !flags_r.fault && op == lbx_pkg::LBX_OP_PARALLEL_INV) |=> (cond_r == ($past(cond_r) | ~$past(opnd)));
	endproperty
	a_parallel: assert property (p_parallel) else $error("parallel inverted contact wrong");

	property p_fault_blocks;
		@(posedge clk) disable iff (!rstn)
		(state_r == S_EXEC && flags_r.fault) |=> (!bit_wr.en && $stable(cond_r));
	endproperty
	a_fault_blocks: assert property (p_fault_blocks) else $error("executed under fault");

	property p_flags_kept;
		@(posedge clk) disable iff (!rstn)
		(state_r == S_EXEC) |=> ({flags_r.carry, flags_r.below, flags_r.match, flags_r.above} == $past({flags_r.carry, flags_r.below, flags_r.match, flags_r.above}));
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flag changed by bit instruction");

	sequence s_ptr_bad;
		state_r == S_PTR && ptr_bad;
	endsequence
	property p_ptr_fault;
		@(posedge clk) disable iff (!rstn)
		s_ptr_bad |=> (flags_r.fault && state_r == S_FETCH);
	endproperty
	a_ptr_fault: assert property (p_ptr_fault) else $error("bad pointer not flagged");

	property p_restart;
		@(posedge clk) disable iff (!rstn)
		scan_done |-> (pc_r == '0);
	endproperty
	a_restart: assert property (p_restart) else $error("scan did not restart at zero");
endmodule

// ==== dv/lbx_mem_model.sv ====
// Program memory and bit data memory seen from the executor's far side
`include "lbx_map.svh"
module lbx_mem_model
(
	input  wire logic                         clk,
	input  wire logic [`LBX_PADDR_W-1:0]      prog_addr,
	output logic      [`LBX_IWORD_W-1:0]      prog_word,
	output logic                              last_is_end,
	input  wire logic [`LBX_BIT_ADDR_W-1:0]   bit_rd_addr,
	output logic                              bit_rd_val,
	input  wire logic [`LBX_BIT_ADDR_W-1:0]   word_rd_addr,
	output logic      [15:0]                  word_rd_val,
	input  wire lbx_pkg::lbx_bit_wr_t         bit_wr
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [`LBX_IWORD_W-1:0] prog [0:1023];
	logic                    bits [0:4095];

	initial
	begin
		for (int k = 0; k < 1024; k++)
			prog[k] = 16'hB001;
		for (int k = 0; k < 4096; k++)
			bits[k] = 1'h0;
	end

	// One word per bit instruction, operands in program order
	assign prog_word = prog[prog_addr];
	// Terminator is function code 01 written as two BCD digits
	assign last_is_end = (prog[1023] == 16'hB001);
	assign bit_rd_val = bits[bit_rd_addr];

	// Pointer words are returned exactly as stored, BCD or not
	always_comb
		for (int k = 0; k < 16; k++)
			word_rd_val[k] = bits[{word_rd_addr[7:0], k[3:0]}];

	always @(posedge clk)
		if (bit_wr.en === 1'h1)
			bits[bit_wr.addr] <= bit_wr.value;
endmodule

// ==== dv/ladder_bit_logic_executor_tb_top.sv ====
// Self-checking bench of the ladder bit logic executor
`include "lbx_map.svh"
module ladder_bit_logic_executor_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed
	{
		logic [3:0] op1;
		logic [3:0] op2;
		logic       a;
		logic       b;
		logic       y;
	} lbx_row_t;
	// Rows: first opcode, second opcode, operand bits, expected coil value
	lbx_row_t rows [12] = '{11'h09F, 11'h09C, 11'h0A5, 11'h0A6, 11'h0AB, 11'h0A8,
		11'h0B1, 11'h0B2, 11'h11B, 11'h12C, 11'h136, 11'h121};
	// Lone first words, pointer word contents and whether a fault is due
	logic [15:0] fw [7] = '{16'h7000, 16'hC000, 16'h1800, 16'h1800, 16'h1800, 16'h1800, 16'h203B};
	logic [15:0] fp [7] = '{16'h0000, 16'h0000, 16'h001A, 16'h0016, 16'h0015, 16'h0001, 16'h0000};
	logic        ff [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
	logic                         clk;
	logic                         rstn;
	logic                         run_mode;
	logic [`LBX_PADDR_W-1:0]      prog_addr;
	logic [`LBX_IWORD_W-1:0]      prog_word;
	logic                         last_is_end;
	logic                         bit_rd_val;
	logic                         running;
	logic                         scan_done;
	logic                         fault_seen;
	logic [`LBX_BIT_ADDR_W-1:0]   bit_rd_addr;
	logic [`LBX_BIT_ADDR_W-1:0]   word_rd_addr;
	logic [15:0]                  word_rd_val;
	lbx_pkg::lbx_bit_wr_t         bit_wr;
	lbx_pkg::lbx_flags_t          flags;
	int                           fail_count;
	int                           check_count;

	lbx_executor u_dut (.clk(clk), .rstn(rstn), .run_mode(run_mode), .prog_addr(prog_addr),
		.prog_word(prog_word), .last_is_end(last_is_end), .bit_rd_addr(bit_rd_addr),
		.bit_rd_val(bit_rd_val), .word_rd_addr(word_rd_addr), .word_rd_val(word_rd_val),
		.bit_wr(bit_wr), .flags(flags), .running(running), .scan_done(scan_done));
	lbx_mem_model u_mem (.clk(clk), .prog_addr(prog_addr), .prog_word(prog_word),
		.last_is_end(last_is_end), .bit_rd_addr(bit_rd_addr), .bit_rd_val(bit_rd_val),
		.word_rd_addr(word_rd_addr), .word_rd_val(word_rd_val), .bit_wr(bit_wr));

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic clr();
		for (int k = 0; k < 1024; k++)
			u_mem.prog[k] = 16'hB001;
	endtask

	// Holds run selected for a number of scans; fault is sampled every cycle
	task automatic run_scan(input int scans);
		int n;
		int done;
		n = 0;
		done = 0;
		fault_seen = 1'h0;
		run_mode = 1'h1;
		while (done < scans && n < 20000)
		begin
			@(negedge clk);
			n++;
			if (scan_done === 1'h1)
				done++;
			if (flags.fault !== 1'h0)
				fault_seen = 1'h1;
		end
		run_mode = 1'h0;
		while (running !== 1'h0 && n < 20000)
		begin
			@(negedge clk);
			n++;
			if (flags.fault !== 1'h0)
				fault_seen = 1'h1;
		end
		if (n >= 20000)
		begin
			fail_count++;
			stop_test();
		end
	endtask

	initial
	begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		rstn = 1'h0;
		run_mode = 1'h0;
		fail_count = 0;
		check_count = 0;
		repeat (4) @(negedge clk);
		chk({6'h00, prog_addr}, 16'h0000);
		chk({9'h000, running, bit_wr.en, flags}, 16'h0000);
		rstn = 1'h1;
		@(negedge clk);
		foreach (rows[i])
		begin
			clr();
			u_mem.prog[0] = {rows[i].op1, 12'h010};
			u_mem.prog[1] = {rows[i].op2, 12'h011};
			u_mem.prog[2] = 16'h9100;
			u_mem.prog[3] = 16'hA101;
			u_mem.bits[12'h010] = rows[i].a;
			u_mem.bits[12'h011] = rows[i].b;
			u_mem.bits[12'h100] = ~rows[i].y;
			u_mem.bits[12'h101] = rows[i].y;
			run_scan(1);
			chk({15'h0000, u_mem.bits[12'h100]}, {15'h0000, rows[i].y});
			chk({15'h0000, u_mem.bits[12'h101]}, {15'h0000, ~rows[i].y});
			chk({11'h000, flags}, 16'h0000);
		end
		// Each scan leaves one pending entry, so ten scans overflow unless cleared
		for (int j = 0; j < 2; j++)
		begin
			clr();
			u_mem.prog[0] = 16'h1010;
			u_mem.prog[1] = 16'h1011;
			u_mem.prog[2] = 16'h7000;
			u_mem.prog[3] = 16'h1012;
			u_mem.prog[4] = 16'h8000;
			u_mem.prog[5] = 16'h9100;
			u_mem.bits[12'h010] = 1'h1;
			u_mem.bits[12'h011] = j[0];
			u_mem.bits[12'h012] = 1'h0;
			u_mem.bits[12'h100] = ~j[0];
			run_scan(10);
			chk({15'h0000, u_mem.bits[12'h100]}, {15'h0000, j[0]});
			chk({15'h0000, fault_seen}, 16'h0000);
		end
		// A series contact keeps the pointed-to bit in the coil; BCD 15 is word 15, BCD 01 word 1
		foreach (fw[i])
		begin
			clr();
			u_mem.prog[0] = fw[i];
			u_mem.prog[1] = 16'h3010;
			u_mem.prog[2] = 16'h9100;
			for (int k = 0; k < 16; k++)
				u_mem.bits[12'h200 + k] = fp[i][k];
			u_mem.bits[12'h010] = 1'h1;
			u_mem.bits[12'h2F0] = 1'h1;
			u_mem.bits[12'h210] = 1'h1;
			// Memory copy of the fault bit disagrees with the flag on purpose
			u_mem.bits[12'h03B] = 1'h1;
			u_mem.bits[12'h100] = 1'h0;
			run_scan(1);
			chk({15'h0000, fault_seen}, {15'h0000, ff[i]});
			chk({15'h0000, u_mem.bits[12'h100]}, {15'h0000, ~ff[i]});
			chk({15'h0000, flags.fault}, 16'h0000);
		end
		// Nine loads in one rung overflow the eight-deep condition store
		clr();
		for (int k = 0; k < 9; k++)
			u_mem.prog[k] = 16'h1010;
		u_mem.prog[9] = 16'h9100;
		u_mem.bits[12'h100] = 1'h0;
		run_scan(1);
		chk({15'h0000, fault_seen}, 16'h0001);
		chk({15'h0000, u_mem.bits[12'h100]}, 16'h0000);
		clr();
		u_mem.prog[1023] = 16'h0000;
		run_mode = 1'h1;
		repeat (10) @(negedge clk);
		chk({15'h0000, running}, 16'h0000);
		chk({6'h00, prog_addr}, 16'h0000);
		run_mode = 1'h0;
		stop_test();
	end
endmodule
